// *** fbo_pkg.sv ***
/*
 * fbo_pkg: shared constants for the parallel nor flash bus controller.
 * assumes a 25 mhz core clock; all pin timings become cycle counts here.
 */
package fbo_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // access time of the array, chip select and address paths
    localparam int SELECT_ACCESS_DELAY_NS = 90;
    localparam int ACC_CYC =
        (SELECT_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // strobe low and high widths for a write
    localparam int WR_PULSE_NS = 45;
    localparam int WR_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset pulse width and recovery before first access
    localparam int RST_PULSE_NS = 500;
    localparam int RST_CYC =
        (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_RECOV_NS = 50;
    localparam int RECOV_CYC =
        (RST_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;

    // ----------------------------------------------------------------
    // register map of the controller
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0; // w: go/op/byte
    localparam logic [3:0] REG_ADDR   = 4'h1; // rw: 20-bit address
    localparam logic [3:0] REG_WDATA  = 4'h2; // rw: write data
    localparam logic [3:0] REG_RDATA  = 4'h3; // r: last read data
    localparam logic [3:0] REG_STATUS = 4'h4; // r: busy, ready pin, state
    localparam int CTRL_GO_BIT   = 0;
    localparam int CTRL_OP_LO    = 1; // two bits of operation code
    localparam int CTRL_BYTE_BIT = 3; // 1 selects byte configuration
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RESET = 2'h2;
    localparam logic [1:0] OP_IDLE  = 2'h3;

    // ----------------------------------------------------------------
    // controller states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_STBY  = 6'h01,
        ST_RD    = 6'h02,
        ST_WR_LO = 6'h04,
        ST_WR_HI = 6'h08,
        ST_RST   = 6'h10,
        ST_RECOV = 6'h20
    } fbo_state_type;
endpackage

// *** fbo_host.sv ***
/*
 * fbo_host: host-side bus controller for an asynchronous nor flash.
 * assumes the flash pins are wired directly; pin inputs are synchronous.
 */
// Behaviour
// - read: select and gate low, strobe high
// - strobe stays high throughout every read
// - command write: strobe, select low, gate high
// - short program mode: two write cycles
`timescale 1ns/1ns
`default_nettype none
module fbo_host
    import fbo_pkg::*;
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // software register port
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // flash control pins, all active low except width select
    output logic             o_chip_sel_n,
    output logic             o_out_gate_n,
    output logic             o_wr_strobe_n,
    output logic             o_flash_rst_n,
    output logic             o_word_mode,
    output logic      [18:0] o_addr,
    // flash data pins
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic      [15:0] o_data_oe,
    // ready pin from the flash, low while busy
    input  wire logic        i_op_done_flag
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fbo_state_type     state_q, state_d;     // sequencer state
    logic [CNT_W-1:0]  cnt_q, cnt_d;         // phase timer
    logic [19:0]       addr_q, addr_d;       // a18..a0 plus low bit
    logic [15:0]       wdata_q, wdata_d;     // data for a write
    logic [15:0]       rdata_q, rdata_d;     // captured read data
    logic              byte_q, byte_d;       // byte configuration
    logic              word_q, word_d;       // width pin, high for words
    logic [31:0]       rreg_q, rreg_d;       // register read data
    logic              ce_q, ce_d;
    logic              oe_q, oe_d;
    logic              we_q, we_d;
    logic              frst_q, frst_d;
    logic [18:0]       pa_q, pa_d;           // address pins
    logic [15:0]       pd_q, pd_d;           // data pins out
    logic [15:0]       pe_q, pe_d;           // data pin enables
    logic              go;                   // software start pulse
    logic [1:0]        op;

    assign go = i_reg_wr && i_reg_addr == REG_CTRL
                && i_reg_wdata[CTRL_GO_BIT];
    assign op = i_reg_wdata[CTRL_OP_LO +: 2];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        byte_d  = byte_q;
        word_d  = word_q;
        ce_d    = ce_q;
        oe_d    = oe_q;
        we_d    = we_q;
        frst_d  = frst_q;
        pa_d    = pa_q;
        pd_d    = pd_q;
        pe_d    = pe_q;
        // plain register writes, only honoured while idle
        if (i_reg_wr && state_q == ST_STBY) begin
            if (i_reg_addr == REG_ADDR) begin
                addr_d = i_reg_wdata[19:0];
            end
            if (i_reg_addr == REG_WDATA) begin
                wdata_d = i_reg_wdata[15:0];
            end
        end
        case (state_q)
            ST_STBY: begin
                // idle: select and reset high leaves the part in standby
                ce_d   = 1'b1;
                oe_d   = 1'b1;
                we_d   = 1'b1;
                frst_d = 1'b1;
                pe_d   = 16'h0000;
                if (go) begin
                    byte_d = i_reg_wdata[CTRL_BYTE_BIT];
                    // own flop so the width pin needs no inverter
                    word_d = ~i_reg_wdata[CTRL_BYTE_BIT];
                    cnt_d  = '0;
                    // address a18..a0 on pins; byte mode adds low bit
                    pa_d = addr_q[19:1];
                    if (op == OP_READ) begin
                        // select and gate low, strobe held high
                        ce_d    = 1'b0;
                        oe_d    = 1'b0;
                        we_d    = 1'b1;
                        state_d = ST_RD;
                    end else if (op == OP_WRITE) begin
                        // gate high first so the bus never fights
                        // one bus cycle per write, so short sequences fit
                        ce_d    = 1'b0;
                        oe_d    = 1'b1;
                        state_d = ST_WR_LO;
                    end else if (op == OP_RESET) begin
                        frst_d  = 1'b0;
                        state_d = ST_RST;
                    end
                end
                // byte mode: line 15 drives the low address bit
                if (go && i_reg_wdata[CTRL_BYTE_BIT]) begin
                    pe_d = 16'h8000;
                    pd_d = {addr_q[0], 15'h0000};
                end
            end
            ST_RD: begin
                // data valid after the access time from select
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(ACC_CYC)) begin
                    // word mode takes all lines, byte mode the low eight
                    rdata_d = byte_q ? {8'h00, i_data[7:0]}
                                     : i_data;
                    ce_d    = 1'b1;
                    oe_d    = 1'b1;
                    pe_d    = 16'h0000;
                    state_d = ST_STBY;
                end
            end
            ST_WR_LO: begin
                // strobe falls after address is set: address latched here
                we_d  = 1'b0;
                pd_d  = byte_q ? {addr_q[0], 7'h00, wdata_q[7:0]}
                               : wdata_q;
                pe_d  = byte_q ? 16'h80ff : 16'hffff;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WR_CYC)) begin
                    // strobe rises before select: data latched here
                    we_d    = 1'b1;
                    cnt_d   = '0;
                    state_d = ST_WR_HI;
                end
            end
            ST_WR_HI: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(WR_CYC)) begin
                    // deselect is harmless to an embedded operation
                    ce_d    = 1'b1;
                    pe_d    = 16'h0000;
                    state_d = ST_STBY;
                end
            end
            ST_RST: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RST_CYC)) begin
                    frst_d  = 1'b1;
                    cnt_d   = '0;
                    state_d = ST_RECOV;
                end
            end
            ST_RECOV: begin
                // wait recovery and until the ready pin returns high
                if (cnt_q != CNT_W'(RECOV_CYC)) begin
                    cnt_d = cnt_q + 1'b1;
                end else if (i_op_done_flag) begin
                    state_d = ST_STBY;
                end
            end
            default: begin
                state_d = ST_STBY;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // register read mux, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        rreg_d = 32'h0000_0000;
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_ADDR:   rreg_d = {12'h000, addr_q};
                REG_WDATA:  rreg_d = {16'h0000, wdata_q};
                REG_RDATA:  rreg_d = {16'h0000, rdata_q};
                REG_STATUS: rreg_d = {24'h000000, state_q,
                                      i_op_done_flag,
                                      state_q != ST_STBY};
                default:    rreg_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= ST_STBY;
            cnt_q   <= '0;
            addr_q  <= 20'h00000;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            byte_q  <= 1'b0;
            word_q  <= 1'b1;
            rreg_q  <= 32'h0000_0000;
            ce_q    <= 1'b1;
            oe_q    <= 1'b1;
            we_q    <= 1'b1;
            frst_q  <= 1'b0;
            pa_q    <= 19'h00000;
            pd_q    <= 16'h0000;
            pe_q    <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            byte_q  <= byte_d;
            word_q  <= word_d;
            rreg_q  <= rreg_d;
            ce_q    <= ce_d;
            oe_q    <= oe_d;
            we_q    <= we_d;
            frst_q  <= frst_d;
            pa_q    <= pa_d;
            pd_q    <= pd_d;
            pe_q    <= pe_d;
        end
    end

    // outputs straight from flip-flops
    assign o_reg_rdata   = rreg_q;
    assign o_chip_sel_n  = ce_q;
    assign o_out_gate_n  = oe_q;
    assign o_wr_strobe_n = we_q;
    assign o_flash_rst_n = frst_q;
    assign o_word_mode   = word_q;
    assign o_addr        = pa_q;
    assign o_data        = pd_q;
    assign o_data_oe     = pe_q;
endmodule
`default_nettype wire

// *** fbo_host_monitor.sv ***
/* fbo_host_monitor: pin timing checks on the flash side.
   assumes it is bound into fbo_host and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module fbo_host_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        o_chip_sel_n,
    input wire logic        o_out_gate_n,
    input wire logic        o_wr_strobe_n,
    input wire logic        o_flash_rst_n,
    input wire logic        o_word_mode,
    input wire logic [15:0] o_data_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------
    // multi-step pin shapes
    // ------------------------------------------------
    sequence s_rd_hold; // gate low four cycles
        !o_out_gate_n[*4] ##1 o_out_gate_n;
    endsequence
    sequence s_wr_pulse; // select outlives the strobe
        !o_wr_strobe_n[*2] ##1 (o_wr_strobe_n && !o_chip_sel_n)
            ##1 !o_chip_sel_n;
    endsequence
    a_rd_we_high: assert property (
        !o_chip_sel_n && !o_out_gate_n |-> o_wr_strobe_n)
        else $error("strobe low in read");
    a_wr_gate_high: assert property (
        !o_wr_strobe_n |-> !o_chip_sel_n && o_out_gate_n)
        else $error("bad write levels");
    a_gate_no_drive: assert property (
        !o_out_gate_n |-> o_data_oe[14:0] == 15'h0)
        else $error("host drives during read");
    a_byte_lsb_drv: assert property (
        !o_word_mode && !o_out_gate_n |-> o_data_oe[15])
        else $error("low address bit not driven");
    a_word_drive: assert property (
        o_word_mode && !o_wr_strobe_n |-> o_data_oe == 16'hffff)
        else $error("word write not full width");
    a_rst_quiet: assert property (
        !o_flash_rst_n |-> o_chip_sel_n && o_out_gate_n && o_wr_strobe_n)
        else $error("access during reset");
    a_rd_hold: assert property (
        $fell(o_out_gate_n) |-> s_rd_hold)
        else $error("read length wrong");
    a_wr_pulse: assert property (
        $fell(o_wr_strobe_n) |-> s_wr_pulse)
        else $error("write pulse wrong");
    a_recov_hold: assert property (
        $rose(o_flash_rst_n) |-> o_chip_sel_n[*3])
        else $error("access in recovery");
endmodule
bind fbo_host fbo_host_monitor fbo_host_monitor_i (.i_core_clk, .i_rst,
    .o_chip_sel_n, .o_out_gate_n, .o_wr_strobe_n, .o_flash_rst_n,
    .o_word_mode, .o_data_oe);
`default_nettype wire

// *** fbo_flash_model.sv ***
/* fbo_flash_model: behavioural nor flash, pin level only.
   assumes the host pins straight from fbo_host; no timing. */
`timescale 1ns/1ns
`default_nettype none
module fbo_flash_model #(
    parameter logic [7:0] ID_CODE = 8'h5e, // arbitrary value
    parameter int         BUSY_NS = 3000
) (
    input  wire logic        i_chip_sel_n,
    input  wire logic        i_out_gate_n,
    input  wire logic        i_wr_strobe_n,
    input  wire logic        i_rst_n,
    input  wire logic        i_word_mode,
    input  wire logic [18:0] i_addr,
    input  wire logic [15:0] i_host_data,
    input  wire logic [15:0] i_host_oe,
    output logic      [15:0] o_bus,
    output logic             o_ready
);
    logic        id_q = 1'h0;   // identifier mode
    logic        byp_q = 1'h0;  // short program mode
    logic        arm_q = 1'h0;  // next write is program data
    logic        busy_q = 1'h0; // embedded operation
    logic        junk = 1'h0;   // undriven lines wander
    logic [15:0] val;           // value the device offers
    logic [15:0] drv;           // lines the device drives
    always #20 junk = ~junk;
    // data taken at strobe rise, the earlier of the two
    always @(posedge i_wr_strobe_n) if (!i_chip_sel_n && i_rst_n) begin
        id_q = o_bus[7:0] == 8'h90;
        // erase confirm, or the data write of a short program
        busy_q = o_bus[7:0] == 8'h30 || arm_q;
        arm_q = byp_q && o_bus[7:0] == 8'ha0;
        if (o_bus[7:0] == 8'h20) byp_q = 1'h1;
    end
    // deselect does not stop it, nor does reset
    always @(posedge busy_q) busy_q <= #(BUSY_NS) 1'h0;
    always @(negedge i_rst_n) begin
        id_q = 1'h0;
        byp_q = 1'h0;
        arm_q = 1'h0;
    end
    assign o_ready = !busy_q;
    always_comb begin
        // data follows the address and holds while it holds, as in sleep
        val = {i_addr[7:0] ^ 8'h3c, i_addr[7:0]};
        if (!i_word_mode) val[7:0] = i_host_data[15] ? val[15:8] : val[7:0];
        if (id_q) val = {8'h00, ID_CODE};
        if (busy_q) val = 16'h0040;
        drv = 16'h0;
        if (!i_chip_sel_n && !i_out_gate_n && i_rst_n)
            drv = i_word_mode ? 16'hffff : 16'h00ff;
        for (int i = 0; i < 16; i++)
            o_bus[i] = i_host_oe[i] ? i_host_data[i] : drv[i] ? val[i] : junk;
    end
endmodule
`default_nettype wire

// *** fbo_host_tb_top.sv ***
/* fbo_host_tb_top: self-checking bench for fbo_host.
   assumes fbo_flash_model on the pins and the bound monitor. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
module fbo_host_tb_top import fbo_pkg::*;;
    typedef struct {logic [1:0] op; logic b; logic [19:0] a;
        logic [15:0] d; logic [15:0] e; logic c;} fbo_row_type;
    localparam logic [7:0] ID = 8'h5e; // arbitrary value
    logic        i_core_clk = 1'h0;
    logic        i_rst = 1'h1;
    logic [3:0]  i_reg_addr = 4'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic        i_reg_wr = 1'h0;
    logic        i_reg_rd = 1'h0;
    logic [31:0] o_reg_rdata, r;
    logic        cs_n, oe_n, we_n, frst_n, word, ready;
    logic [18:0] addr;
    logic [15:0] bus, hd, hoe;
    int          error_cnt = 0;
    int          compares = 0;
    // op, byte, address, write data, expected, check
    fbo_row_type rows [15] = '{
        '{OP_READ, 0, 20'hffffe, 0, 16'hc3ff, 1},
        '{OP_WRITE, 0, 20'h00aaa, 16'h0090, 0, 0},
        '{OP_READ, 0, 20'h00024, 0, {8'h00, ID}, 1},
        '{OP_WRITE, 0, 20'h0, 16'h00f0, 0, 0},
        '{OP_READ, 1, 20'h00025, 0, 16'h002e, 1},
        '{OP_READ, 1, 20'h00024, 0, 16'h0012, 1},
        '{OP_WRITE, 1, 20'h0, 16'h0030, 0, 0},
        '{OP_READ, 0, 20'h00024, 0, 16'h0040, 1},
        '{OP_RESET, 0, 20'h0, 0, 0, 0},
        '{OP_READ, 0, 20'h00024, 0, 16'h2e12, 1},
        '{OP_WRITE, 0, 20'h0, 16'h0020, 0, 0},
        '{OP_WRITE, 0, 20'h0, 16'h00a0, 0, 0},
        '{OP_WRITE, 0, 20'h0, 16'h0055, 0, 0},
        '{OP_READ, 0, 20'h00024, 0, 16'h0040, 1},
        '{OP_RESET, 0, 20'h0, 0, 0, 0}};
    always #20 i_core_clk = ~i_core_clk;
    fbo_host fbo_host_i (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_chip_sel_n(cs_n),
        .o_out_gate_n(oe_n), .o_wr_strobe_n(we_n), .o_flash_rst_n(frst_n),
        .o_word_mode(word), .o_addr(addr), .i_data(bus), .o_data(hd),
        .o_data_oe(hoe), .i_op_done_flag(ready));
    fbo_flash_model #(.ID_CODE(ID)) fbo_flash_model_i (.i_chip_sel_n(cs_n),
        .i_out_gate_n(oe_n), .i_wr_strobe_n(we_n), .i_rst_n(frst_n),
        .i_word_mode(word), .i_addr(addr), .i_host_data(hd),
        .i_host_oe(hoe), .o_bus(bus), .o_ready(ready));
    // ------------------------------------------------
    // register port cycles
    // ------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'h1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'h0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        i_reg_rd <= 1'h1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'h0;
        @(negedge i_core_clk);
        d = o_reg_rdata;
    endtask
    // one flash operation, then poll busy with a bound
    task automatic run(input fbo_row_type w);
        wr(REG_ADDR, {12'h0, w.a});
        wr(REG_WDATA, {16'h0, w.d});
        wr(REG_CTRL, {28'h0, w.b, w.op, 1'h1});
        for (int n = 0; n < 300; n++) begin
            rd(REG_STATUS, r);
            if (r[0] === 1'h0) break;
        end
        `CHK(r[0], 1'h0)
    endtask
    task complete_run;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        $display("unexpected %0t: watchdog expired", $time);
        complete_run;
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        `CHK({frst_n, cs_n, word}, 3'h3)
        i_rst <= 1'h0;
        foreach (rows[k]) begin
            run(rows[k]);
            if (k == 7) `CHK(r[1], 1'h0)
            if (rows[k].c) begin
                rd(REG_RDATA, r);
                `CHK(r, {16'h0, rows[k].e})
            end
        end
        // unmapped index reads as zero
        rd(4'hf, r);
        `CHK(r, 32'h0)
        // reset again mid-run, then read with no command
        @(posedge i_core_clk);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        `CHK({frst_n, cs_n, word}, 3'h3)
        i_rst <= 1'h0;
        rd(REG_STATUS, r);
        `CHK(r[1:0], 2'h2)
        run(rows[0]);
        rd(REG_RDATA, r);
        `CHK(r[15:0], rows[0].e)
        complete_run;
    end
endmodule
`default_nettype wire
